// *** bridge_memory_window_regs.sv ***
// Purpose: base and limit registers of the two bridge memory windows, with address match
// Assumes: APB slave, zero wait states, inputs synchronous to clk
// Notes: unmapped addresses read zero and answer without error; writes there are dropped
`default_nettype none

// Summary of operation
// - non-prefetch bottom field bits 15:4 writable
// - non-prefetch bottom low 20 bits zero
// - non-prefetch top bits 31:20, low ones
// - non-prefetch window decides memory forwarding
// - prefetch low nibbles read 1h, read-only
// - prefetch bottom bits 15:4, low zero
// - prefetch top bits 31:20, low FFFFFh
// - upper 32 bits of prefetch bottom
// - prefetch window decides memory forwarding
// - writable fields reset to zero
// - upper 32 bits of prefetch top
module bridge_memory_window_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire bridge_window_pkg::apb_req_t apb_req,
    output bridge_window_pkg::apb_rsp_t apb_rsp,
    input wire logic [63:0] txn_addr,
    input wire logic txn_is_64,
    output logic hit_nonpref,
    output logic hit_pref,
    output logic forward_hit,
    output bridge_window_pkg::window32_t nonpref_window,
    output bridge_window_pkg::window64_t pref_window
);

    logic [11:0] nonpref_window_bottom;
    logic [11:0] nonpref_window_top;
    logic [11:0] pref_window_bottom;
    logic [11:0] pref_window_top;
    logic [31:0] pref_window_bottom_high;
    logic [31:0] pref_window_top_high;
    logic [31:0] next_prdata;
    logic wr_access;
    logic rd_access;

    // merge write data into a word under byte strobes
    function automatic logic [31:0] apply_strobe(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] strb
    );
        logic [31:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // image of a base/limit pair word as software sees it
    function automatic logic [31:0] pair_word(
        input logic [11:0] bottom,
        input logic [11:0] top,
        input logic [3:0] nibble
    );
        pair_word = {top, nibble, bottom, nibble};
    endfunction

    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_access = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    // zero wait states: every access completes in its first access cycle
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = 1'b0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nonpref_window_bottom <= bridge_window_pkg::field_reset;
            nonpref_window_top <= bridge_window_pkg::field_reset;
        end else if (wr_access && apb_req.paddr == bridge_window_pkg::nonpref_window_off) begin
            logic [31:0] merged;
            merged = apply_strobe(pair_word(nonpref_window_bottom, nonpref_window_top,
                                            bridge_window_pkg::reserved_value),
                                  apb_req.pwdata, apb_req.pstrb);
            nonpref_window_bottom <= merged[bridge_window_pkg::bottom_msb:
                                            bridge_window_pkg::bottom_lsb];
            nonpref_window_top <= merged[bridge_window_pkg::top_msb:
                                         bridge_window_pkg::top_lsb];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pref_window_bottom <= bridge_window_pkg::field_reset;
            pref_window_top <= bridge_window_pkg::field_reset;
        end else if (wr_access && apb_req.paddr == bridge_window_pkg::pref_window_off) begin
            logic [31:0] merged;
            merged = apply_strobe(pair_word(pref_window_bottom, pref_window_top,
                                            bridge_window_pkg::addr64_indicator),
                                  apb_req.pwdata, apb_req.pstrb);
            pref_window_bottom <= merged[bridge_window_pkg::bottom_msb:
                                         bridge_window_pkg::bottom_lsb];
            pref_window_top <= merged[bridge_window_pkg::top_msb:
                                      bridge_window_pkg::top_lsb];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pref_window_bottom_high <= bridge_window_pkg::high_reset;
        end else if (wr_access && apb_req.paddr == bridge_window_pkg::pref_bottom_high_off) begin
            pref_window_bottom_high <= apply_strobe(pref_window_bottom_high, apb_req.pwdata,
                                                    apb_req.pstrb);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pref_window_top_high <= bridge_window_pkg::high_reset;
        end else if (wr_access && apb_req.paddr == bridge_window_pkg::pref_top_high_off) begin
            pref_window_top_high <= apply_strobe(pref_window_top_high, apb_req.pwdata,
                                                 apb_req.pstrb);
        end
    end

    // read mux; captured in setup so prdata is a flop valid in the access cycle
    always_comb begin
        next_prdata = 32'h00000000;
        case (apb_req.paddr)
            bridge_window_pkg::nonpref_window_off: begin
                next_prdata = pair_word(nonpref_window_bottom, nonpref_window_top,
                                        bridge_window_pkg::reserved_value);
            end
            bridge_window_pkg::pref_window_off: begin
                next_prdata = pair_word(pref_window_bottom, pref_window_top,
                                        bridge_window_pkg::addr64_indicator);
            end
            bridge_window_pkg::pref_bottom_high_off: begin
                next_prdata = pref_window_bottom_high;
            end
            bridge_window_pkg::pref_top_high_off: begin
                next_prdata = pref_window_top_high;
            end
            default: begin
                next_prdata = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            apb_rsp.prdata <= 32'h00000000;
        end else if (rd_access) begin
            apb_rsp.prdata <= next_prdata;
        end
    end

    // decoded windows, registered so the routing side sees clean flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nonpref_window <= '0;
            pref_window <= '0;
        end else begin
            nonpref_window.bottom <= {nonpref_window_bottom, bridge_window_pkg::bottom_fill};
            nonpref_window.top <= {nonpref_window_top, bridge_window_pkg::top_fill};
            pref_window.bottom <= {pref_window_bottom_high, pref_window_bottom,
                                   bridge_window_pkg::bottom_fill};
            pref_window.top <= {pref_window_top_high, pref_window_top,
                                bridge_window_pkg::top_fill};
        end
    end

    // a window with bottom above top matches nothing; the reset state forwards addresses 0 to FFFFFh
    // nonpref range match
    always_comb begin
        hit_nonpref = (txn_addr[63:32] == 32'h00000000 || !txn_is_64)
                      && txn_addr[31:0] >= nonpref_window.bottom
                      && txn_addr[31:0] <= nonpref_window.top;
    end

    always_comb begin
        logic [63:0] addr;
        addr = txn_is_64 ? txn_addr : {32'h00000000, txn_addr[31:0]};
        hit_pref = addr >= pref_window.bottom && addr <= pref_window.top;
    end

    assign forward_hit = hit_nonpref || hit_pref;

endmodule // bridge_memory_window_regs
`default_nettype wire

// *** bridge_window_pkg.sv ***
// Purpose: shared constants and types for the bridge memory window registers
// Assumes: 32-bit APB data, byte addresses equal the register offsets
// Notes: the address-decode outputs are consumed by the packet routing logic
`default_nettype none
package bridge_window_pkg;
    localparam logic [7:0] nonpref_window_off = 8'h20;
    localparam logic [7:0] pref_window_off = 8'h24;
    localparam logic [7:0] pref_bottom_high_off = 8'h28;
    localparam logic [7:0] pref_top_high_off = 8'h2c;
    localparam int bottom_lsb = 4;
    localparam int bottom_msb = 15;
    localparam int top_lsb = 20;
    localparam int top_msb = 31;
    localparam int ind_base_lsb = 0;
    localparam int ind_top_lsb = 16;
    localparam logic [3:0] addr64_indicator = 4'h1;
    localparam logic [3:0] reserved_value = 4'h0;
    localparam logic [11:0] field_reset = 12'h000;
    localparam logic [31:0] high_reset = 32'h00000000;
    localparam logic [19:0] bottom_fill = 20'h00000;
    localparam logic [19:0] top_fill = 20'hfffff;

    typedef struct packed {
        logic [31:0] bottom;
        logic [31:0] top;
    } window32_t;

    typedef struct packed {
        logic [63:0] bottom;
        logic [63:0] top;
    } window64_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;
endpackage
`default_nettype wire

// *** bridge_memory_window_regs_monitor.sv ***
// Purpose: assertions on the bridge memory window register ports
// Assumes: zero wait state apb, decoded windows lag a write by one edge
// Notes: hit checks skip the edge right after a write, while windows settle
`default_nettype none
module bridge_memory_window_regs_monitor (
    input wire logic clk,
    input wire logic rst_b,
    input wire bridge_window_pkg::apb_req_t apb_req,
    input wire bridge_window_pkg::apb_rsp_t apb_rsp,
    input wire logic [63:0] txn_addr,
    input wire logic txn_is_64,
    input wire logic hit_nonpref,
    input wire logic hit_pref,
    input wire logic forward_hit,
    input wire bridge_window_pkg::window32_t nonpref_window,
    input wire bridge_window_pkg::window64_t pref_window
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic acc, wacc, wr;
    logic [63:0] a64;
    assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign wacc = acc && apb_req.pwrite;
    assign wr = wacc && apb_req.pstrb == 4'hf;
    assign a64 = txn_is_64 ? txn_addr : {32'h0, txn_addr[31:0]};
    a_np_fill: assert property (
        $past(rst_b) |-> nonpref_window.bottom[19:0] == 20'h0
        && nonpref_window.top[19:0] == 20'hfffff)
        else $error("nonpref fill bits wrong");
    a_pref_fill: assert property (
        $past(rst_b) |-> pref_window.bottom[19:0] == 20'h0
        && pref_window.top[19:0] == 20'hfffff)
        else $error("pref fill bits wrong");
    a_np_write: assert property (
        wr && apb_req.paddr == 8'h20 |-> ##2 nonpref_window.bottom[31:20]
        == $past(apb_req.pwdata[15:4], 2)
        && nonpref_window.top[31:20] == $past(apb_req.pwdata[31:20], 2))
        else $error("nonpref window not taken from write");
    a_pref_upper: assert property (
        wr && apb_req.paddr[7:3] == 5'h05 |-> ##2
        (apb_req.paddr[2] ? pref_window.top[63:32] : pref_window.bottom[63:32])
        == $past(apb_req.pwdata, 2))
        else $error("pref upper half wrong");
    a_ro_nibble: assert property (
        acc && !apb_req.pwrite && apb_req.paddr == 8'h24 |-> apb_rsp.prdata[3:0] == 4'h1
        && apb_rsp.prdata[19:16] == 4'h1)
        else $error("pref indicator nibble wrong");
    a_rsvd_zero: assert property (
        acc && !apb_req.pwrite && apb_req.paddr == 8'h20 |-> apb_rsp.prdata[3:0] == 4'h0
        && apb_rsp.prdata[19:16] == 4'h0)
        else $error("reserved nibble not zero");
    a_np_match: assert property (
        $past(rst_b) && !$past(wacc) |-> hit_nonpref
        == (a64 >= {32'h0, nonpref_window.bottom} && a64 <= {32'h0, nonpref_window.top}))
        else $error("nonpref hit wrong");
    a_pref_match: assert property (
        $past(rst_b) && !$past(wacc) |-> hit_pref
        == (a64 >= pref_window.bottom && a64 <= pref_window.top)
        && forward_hit == (hit_pref || hit_nonpref))
        else $error("pref hit wrong");
endmodule // bridge_memory_window_regs_monitor
bind bridge_memory_window_regs bridge_memory_window_regs_monitor
    i_bridge_memory_window_regs_monitor (
    .clk(clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp), .txn_addr(txn_addr),
    .txn_is_64(txn_is_64), .hit_nonpref(hit_nonpref), .hit_pref(hit_pref),
    .forward_hit(forward_hit), .nonpref_window(nonpref_window), .pref_window(pref_window));
`default_nettype wire

// *** bridge_memory_window_regs_tb.sv ***
// Purpose: self-checking bench for the bridge memory window registers
// Assumes: zero wait state apb slave, fixed seed
// Notes: shadow words model byte lanes; masks hide read-only nibbles
`default_nettype none
module bridge_memory_window_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, txn_is_64, hit_nonpref, hit_pref, forward_hit;
    logic [63:0] txn_addr;
    logic [31:0] rd, d;
    logic [31:0] sh [4];
    logic [31:0] rw [4] = '{32'hfff0fff0, 32'hfff0fff0, 32'hffffffff, 32'hffffffff};
    logic [31:0] ro [4] = '{32'h0, 32'h00010001, 32'h0, 32'h0};
    logic [3:0] s;
    bridge_window_pkg::apb_req_t apb_req;
    bridge_window_pkg::apb_rsp_t apb_rsp;
    bridge_window_pkg::window32_t nonpref_window;
    bridge_window_pkg::window64_t pref_window;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'haade;
    int j;
    bridge_memory_window_regs i_bridge_memory_window_regs (.clk(clk), .rst_b(rst_b),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .txn_addr(txn_addr), .txn_is_64(txn_is_64),
        .hit_nonpref(hit_nonpref), .hit_pref(hit_pref), .forward_hit(forward_hit),
        .nonpref_window(nonpref_window), .pref_window(pref_window));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic test_done();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // idle edge first, so no signal is driven twice in one step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
            input logic [3:0] st, output logic [31:0] q);
        @(posedge clk);
        apb_req <= '{a, 1'b1, 1'b0, w, wd, st};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do @(posedge clk); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        check({apb_rsp.pready, apb_rsp.pslverr}, 2'b10);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic check_all();
        logic [63:0] nb, nt, pb, pt, a;
        logic [63:0] c [5];
        logic en, ep;
        nb = {32'h0, sh[0][15:4], 20'h0};
        nt = {32'h0, sh[0][31:20], 20'hfffff};
        pb = {sh[2], sh[1][15:4], 20'h0};
        pt = {sh[3], sh[1][31:20], 20'hfffff};
        check(nonpref_window, {nb[31:0], nt[31:0]});
        check(pref_window, {pb, pt});
        c = '{nb, nt, nt + 64'h1, pb - 64'h1, pt};
        foreach (c[i]) begin
            txn_addr <= c[i];
            txn_is_64 <= 1'($random(seed));
            @(posedge clk);
            a = txn_is_64 ? txn_addr : {32'h0, txn_addr[31:0]};
            en = a >= nb && a <= nt;
            ep = a >= pb && a <= pt;
            check({hit_nonpref, hit_pref, forward_hit}, {en, ep, en | ep});
        end
    endtask
    initial begin
        #20000;
        n_mismatch++;
        test_done();
    end
    initial begin
        rst_b = 1'b0;
        apb_req = '0;
        txn_addr = '0;
        txn_is_64 = 1'b0;
        sh = '{default: 32'h0};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        // unmapped places drop writes and read zero
        apb(8'h1c, 1'b1, 32'hffffffff, 4'hf, rd);
        apb(8'h30, 1'b0, 32'h0, 4'h0, rd);
        check(rd, 32'h0);
        for (int k = 0; k < 40; k++) begin
            j = (k < 4) ? k : int'($unsigned($random(seed)) % 4);
            if (k >= 4) begin
                d = (k < 8) ? 32'hffffffff : $random(seed);
                s = (k % 5 == 0) ? 4'($random(seed)) : 4'hf;
                apb(8'h20 + 8'(4 * j), 1'b1, d, s, rd);
                for (int b = 0; b < 4; b++)
                    if (s[b]) sh[j][8 * b +: 8] = d[8 * b +: 8];
            end
            apb(8'h20 + 8'(4 * j), 1'b0, 32'h0, 4'h0, rd);
            check(rd, sh[j] & rw[j] | ro[j]);
            check_all();
        end
        test_done();
    end
endmodule // bridge_memory_window_regs_tb
`default_nettype wire
